// ---- design/power_shutdown_wakeup.sv ----
// shutdown and wake-up controller with ahb-lite register slave
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module power_shutdown_wakeup
  import power_shutdown_pkg::*;
(
  // clock and reset, permanent slow clock
  input wire logic clk,
  input wire logic reset,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // pins
  input wire logic wake_in0,
  input wire logic alarmIn,
  output logic power_off_out,
  // interrupt
  output logic irq
);
  logic dataPhase;
  logic dataWrite;
  logic [7:0] dataAddr;
  logic [31:0] cfgReg;
  logic [31:0] statReg;
  logic [31:0] maskReg;
  logic wakeS1;
  logic wakeS2;
  logic alarmS1;
  logic alarmS2;
  logic alarmPrev;
  logic alarmEvent;
  logic wakeValid;
  logic cmdAccept;
  logic [1:0] cmdPipe;
  logic statRead;
  logic statWrite;
  logic wakeRelease;
  logic [31:0] next_stat;
  wake_cfg_t cfg;

  // bus: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture
  always_ff @(posedge clk) begin
    if (reset) begin
      dataPhase <= 1'b0;
      dataWrite <= 1'b0;
      dataAddr <= 8'h00;
    end else if (hready) begin
      dataPhase <= hsel & htrans[1];
      dataWrite <= hwrite;
      dataAddr <= haddr[7:0];
    end
  end

  // keyed command: wrong key drops the write entirely
  assign cmdAccept = dataPhase && dataWrite && dataAddr == OFF_CMD
    && hwdata[KEY_LSB +: 8] == UNLOCK_VALUE
    && hwdata[CMD_BIT];

  assign statRead = dataPhase && !dataWrite && dataAddr == OFF_STAT;
  assign statWrite = dataPhase && dataWrite && dataAddr == OFF_STAT;

  // configuration and mask registers
  always_ff @(posedge clk) begin
    if (reset) begin
      cfgReg <= CFG_RESET;
      maskReg <= 32'h00000000;
    end else if (dataPhase && dataWrite) begin
      if (dataAddr == OFF_CFG) cfgReg <= hwdata & CFG_MASK;
      if (dataAddr == OFF_IMASK) maskReg <= hwdata & STAT_MASK;
    end
  end

  assign cfg.edgeSel = edge_sel_t'(cfgReg[SEL_LSB +: 2]);
  assign cfg.debounce = cfgReg[DEB_LSB +: 4];
  assign cfg.alarmWakeEn = cfgReg[ALARM_EN_BIT];

  // read data, registered at the address phase
  always_ff @(posedge clk) begin
    if (reset) hrdata <= 32'h00000000;
    else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        OFF_CFG: hrdata <= cfgReg;
        OFF_STAT: hrdata <= next_stat;
        OFF_IMASK: hrdata <= maskReg;
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // pin synchronisers, single clock domain only
  always_ff @(posedge clk) begin
    if (reset) begin
      wakeS1 <= 1'b0;
      wakeS2 <= 1'b0;
      alarmS1 <= 1'b0;
      alarmS2 <= 1'b0;
      alarmPrev <= 1'b0;
    end else begin
      wakeS1 <= wake_in0;
      wakeS2 <= wakeS1;
      alarmS1 <= alarmIn;
      alarmS2 <= alarmS1;
      alarmPrev <= alarmS2;
    end
  end

  // rising alarm edge, only when enabled; a held alarm never wakes
  assign alarmEvent = alarmS2 & ~alarmPrev & cfg.alarmWakeEn;

  wake_debounce #(
    .CNT_W(9)
  ) u_debounce (
    .clk(clk),
    .reset(reset),
    .wakeLevel(wakeS2),
    .cfg(cfg),
    .wakeValid(wakeValid)
  );

  assign wakeRelease = wakeValid | alarmEvent;

  // status flags; hardware set wins over read or write-one clear
  always_comb begin
    next_stat = statReg;
    if (statRead) next_stat = 32'h00000000;
    if (statWrite) next_stat = statReg & ~hwdata;
    if (wakeValid) next_stat[WAKE_FLAG_BIT] = 1'b1;
    if (alarmEvent) next_stat[ALARM_FLAG_BIT] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (reset) statReg <= 32'h00000000;
    else statReg <= next_stat;
  end

  assign irq = |(statReg & maskReg);

  // two-cycle delay from accepted command
  always_ff @(posedge clk) begin
    if (reset) cmdPipe <= 2'b00;
    else cmdPipe <= {cmdPipe[0], cmdAccept};
  end

  // power-off holds until a qualified wake
  always_ff @(posedge clk) begin
    if (reset) power_off_out <= 1'b0;
    else if (wakeRelease) power_off_out <= 1'b0;
    else if (cmdPipe[CMD_DELAY-1]) power_off_out <= 1'b1;
  end

  sequence s_cmd_accepted;
    cmdAccept && !wakeRelease;
  endsequence

  sequence s_quiet2;
    !wakeRelease [*3];
  endsequence

  a_cmd_delay: assert property (@(posedge clk) disable iff (reset)
    (s_cmd_accepted ##0 s_quiet2) |-> ##1 power_off_out)
    else $error("power-off not asserted two cycles after command");

  a_cmd_not_early: assert property (@(posedge clk) disable iff (reset)
    (!power_off_out && !cmdPipe[0] && !cmdPipe[1]) |=>
      !power_off_out)
    else $error("power-off asserted without delayed command");

  a_bad_key: assert property (@(posedge clk) disable iff (reset)
    (dataPhase && dataWrite && dataAddr == OFF_CMD
      && hwdata[31:24] != UNLOCK_VALUE) |-> !cmdAccept)
    else $error("command accepted with wrong key");

  a_zero_cmd: assert property (@(posedge clk) disable iff (reset)
    (dataPhase && dataWrite && !hwdata[0]) |-> !cmdAccept)
    else $error("command accepted with command bit clear");

  a_hold_off: assert property (@(posedge clk) disable iff (reset)
    (power_off_out && !wakeValid && !alarmEvent) |=>
      power_off_out)
    else $error("power-off released without wake");

  a_wake_release: assert property (@(posedge clk) disable iff (reset)
    wakeValid |=> (!power_off_out && statReg[0]))
    else $error("debounced wake did not release or flag");

  a_alarm_ignored: assert property (@(posedge clk) disable iff (reset)
    !cfgReg[17] |-> !alarmEvent)
    else $error("alarm acted while disabled");

  a_alarm_edge: assert property (@(posedge clk) disable iff (reset)
    ($rose(alarmS2) && cfgReg[17]) |=> statReg[17])
    else $error("enabled alarm edge not flagged");

  a_read_clears: assert property (@(posedge clk) disable iff (reset)
    (statRead && !wakeValid && !alarmEvent) |=> statReg == 32'h0)
    else $error("status read did not clear flags");
endmodule
`default_nettype wire

// ---- design/power_shutdown_pkg.sv ----
// constants and types for the shutdown and wake-up controller
// Function
// - runs on one permanent clock; no gating of any register.
// - keyed command write with command bit 1 asserts power-off; bit 0 does nothing.
// - whole command write ignored unless bits 31..24 carry the unlock value.
// - power-off output changes two clock cycles after an accepted command.
// - edge selector: 0 off, 1 rising, 2 falling, 3 any edge.
// - wake valid after new level held debounce*16+1 consecutive cycles.
// - selected edge starts debounce counter; reaching target releases power-off.
// - any input change before target clears counter, no release; counting restarts if that edge is itself selected.
// - wake input flag bit 0 set on wake event, cleared by status read.
// - alarm wake enable bit 17 lets alarm release power-off; else ignored.
// - alarm is a rising-edge event detected after two-flop synchronisation.
// - alarm wake flag bit 17 set on enabled alarm, cleared by status read.
package power_shutdown_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_CFG = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_IMASK = 8'h0c;
  // command fields
  localparam logic [7:0] UNLOCK_VALUE = 8'ha5;
  localparam int KEY_LSB = 24;
  localparam int CMD_BIT = 0;
  // configuration fields
  localparam int SEL_LSB = 0;
  localparam int DEB_LSB = 4;
  localparam int ALARM_EN_BIT = 17;
  localparam logic [31:0] CFG_RESET = 32'h00000003;
  localparam logic [31:0] CFG_MASK = 32'h000200f3;
  // status fields
  localparam int WAKE_FLAG_BIT = 0;
  localparam int ALARM_FLAG_BIT = 17;
  localparam logic [31:0] STAT_MASK = 32'h00020001;
  // timing
  localparam int CMD_DELAY = 2;
  localparam int DEB_SCALE = 16;
  // wake edge selector codes
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_UP = 2'b01,
    edge_down = 2'b10,
    EDGE_ANY = 2'b11
  } edge_sel_t;
  // debounce controller states
  typedef enum logic [1:0] {
    DB_IDLE = 2'b00,
    DB_COUNT = 2'b01
  } deb_state_t;
  // configuration as carried to the debouncer
  typedef struct packed {
    logic alarmWakeEn;
    logic [3:0] debounce;
    edge_sel_t edgeSel;
  } wake_cfg_t;
endpackage

// ---- design/wake_debounce.sv ----
// edge detector and debounce counter for the wake input
`timescale 1ns/1ns
`default_nettype none
module wake_debounce
  import power_shutdown_pkg::*;
#(
  parameter int CNT_W = 9
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // synchronised input and settings
  input wire logic wakeLevel,
  input wire wake_cfg_t cfg,
  // qualified wake pulse
  output logic wakeValid
);
  logic prevLevel;
  deb_state_t state;
  logic [CNT_W-1:0] count;
  logic rise;
  logic fall;
  logic trigger;
  logic changed;
  logic [CNT_W-1:0] target;

  // target count: debounce*16 + 1 cycles of stable level
  assign target = CNT_W'(cfg.debounce * DEB_SCALE);
  assign rise = wakeLevel & ~prevLevel;
  assign fall = ~wakeLevel & prevLevel;
  assign changed = rise | fall;

  // edge selector decode
  always_comb begin
    case (cfg.edgeSel)
      EDGE_NONE: trigger = 1'b0;
      EDGE_UP: trigger = rise;
      edge_down: trigger = fall;
      EDGE_ANY: trigger = changed;
      default: trigger = 1'b0;
    endcase
  end

  // previous sample for edge detection
  always_ff @(posedge clk) begin
    if (reset) prevLevel <= 1'b0;
    else prevLevel <= wakeLevel;
  end

  // count cycles while the new level holds
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= DB_IDLE;
      count <= '0;
      wakeValid <= 1'b0;
    end else begin
      wakeValid <= 1'b0;
      case (state)
        DB_IDLE: begin
          count <= '0;
          if (trigger) begin
            state <= DB_COUNT;
            if (target == '0) begin
              wakeValid <= 1'b1;
              state <= DB_IDLE;
            end
          end
        end
        DB_COUNT: begin
          if (changed) begin
            // a bounce restarts only if the new edge is itself selected
            count <= '0;
            state <= trigger ? DB_COUNT : DB_IDLE;
          end else if (count + 1'b1 == target) begin
            wakeValid <= 1'b1;
            state <= DB_IDLE;
            count <= '0;
          end else begin
            count <= count + 1'b1;
          end
        end
        default: state <= DB_IDLE;
      endcase
    end
  end

  a_bounce_clears: assert property (@(posedge clk) disable iff (reset)
    (state == DB_COUNT && changed && !trigger) |=>
      (state == DB_IDLE && !wakeValid))
    else $error("bounce did not clear debounce counter");

  a_no_detect: assert property (@(posedge clk) disable iff (reset)
    (state == DB_IDLE && cfg.edgeSel == EDGE_NONE) |=>
      state == DB_IDLE)
    else $error("detection ran while disabled");
endmodule
`default_nettype wire

// ---- sim/wake_source_model.sv ----
// push-button and clock alarm model on the far side of the pins
`timescale 1ns/1ns
`default_nettype none
module wake_source_model (
  // pins toward the controller
  output logic wakePin,
  output logic alarm
);
  // both idle low at time zero
  initial begin
    wakePin = 1'b0;
    alarm = 1'b0;
  end
  // button level, changed just after a rising edge
  task automatic press(input logic v);
    wakePin <= v;
  endtask
  // alarm dropped before any shutdown, else no rise can follow
  task automatic ring(input logic v);
    alarm <= v;
  endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench for the shutdown and wake-up controller
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import power_shutdown_pkg::*;
  logic clk = 0, reset = 1, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, wakePin, alarm, powerOff, irq, d, ex;
  int mismatches = 0, cmp_count = 0;
  // clock
  initial forever #5 clk = ~clk;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  power_shutdown_wakeup dut (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .wake_in0(wakePin),
    .alarmIn(alarm), .power_off_out(powerOff), .irq(irq));
  wake_source_model m (.wakePin(wakePin), .alarm(alarm));
  // compare and count
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one place that ends the run
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // wait for hready, bounded so a stuck slave cannot hang us
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      give_verdict();
    end
  endtask
  // one ahb-lite single word, read data left in rd
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] dat);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= dat;
    rdy();
    rd = hrdata;
  endtask
  task automatic shut();
    xfer(1'b1, OFF_CMD, {UNLOCK_VALUE, 24'h000001});
  endtask
  task automatic pin(input logic v);
    @(posedge clk);
    m.press(v);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    xfer(1'b0, OFF_CFG, 0);
    chk("cfg reset", CFG_RESET, rd);
    xfer(1'b0, OFF_STAT, 0);
    chk("stat reset", 0, rd);
    xfer(1'b0, 8'h10, 0);
    chk("unmapped", 0, rd);
    chk("hresp", 0, {31'h0, hresp});
    chk("off reset", 0, {31'h0, powerOff});
    chk("irq reset", 0, {31'h0, irq});
    $display("test reset done");
    // wrong key, then right key with command bit clear
    xfer(1'b1, OFF_CMD, 32'h5a000001);
    xfer(1'b1, OFF_CMD, {UNLOCK_VALUE, 24'h0});
    wt(6);
    chk("ignored cmd", 0, {31'h0, powerOff});
    shut();
    wt(1);
    chk("off at E+1", 0, {31'h0, powerOff});
    wt(1);
    chk("off at E+2", 1, {31'h0, powerOff});
    wt(50);
    chk("off holds", 1, {31'h0, powerOff});
    $display("test command done");
    // rising, debounce 1: a short pulse must be filtered
    xfer(1'b1, OFF_CFG, 32'h00000011);
    pin(1'b1);
    wt(5);
    pin(1'b0);
    wt(40);
    chk("glitch", 1, {31'h0, powerOff});
    pin(1'b1);
    wt(15);
    chk("early", 1, {31'h0, powerOff});
    wt(15);
    chk("debounced", 0, {31'h0, powerOff});
    xfer(1'b0, OFF_STAT, 0);
    chk("wake flag", 32'h1, rd);
    xfer(1'b0, OFF_STAT, 0);
    chk("flag cleared", 0, rd);
    $display("test debounce done");
    // every edge code against both directions
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 2; k++) begin
        d = k[0];
        ex = (s == 3) || (s == 1 && d) || (s == 2 && !d);
        xfer(1'b1, OFF_CFG, {30'h0, s[1:0]});
        pin(!d);
        wt(10);
        shut();
        wt(4);
        pin(d);
        wt(10);
        chk("edge mode", {31'h0, !ex}, {31'h0, powerOff});
        xfer(1'b0, OFF_STAT, 0);
      end
    end
    $display("test edge modes done");
    // interrupt raised, cleared by read, then masked
    xfer(1'b1, OFF_CFG, 32'h00000003);
    xfer(1'b1, OFF_IMASK, STAT_MASK);
    pin(!wakePin);
    wt(10);
    chk("irq set", 1, {31'h0, irq});
    xfer(1'b0, OFF_STAT, 0);
    wt(1);
    chk("irq clear", 0, {31'h0, irq});
    xfer(1'b1, OFF_IMASK, 0);
    pin(!wakePin);
    wt(10);
    chk("irq masked", 0, {31'h0, irq});
    xfer(1'b0, OFF_STAT, 0);
    $display("test interrupt done");
    // enabled alarm releases, disabled alarm does not
    xfer(1'b1, OFF_CFG, 32'h00020000);
    shut();
    wt(4);
    @(posedge clk);
    m.ring(1'b1);
    wt(8);
    chk("alarm wake", 0, {31'h0, powerOff});
    xfer(1'b0, OFF_STAT, 0);
    chk("alarm flag", 32'h00020000, rd);
    m.ring(1'b0);
    xfer(1'b1, OFF_CFG, 0);
    shut();
    wt(4);
    @(posedge clk);
    m.ring(1'b1);
    wt(10);
    chk("alarm off", 1, {31'h0, powerOff});
    $display("test alarm done");
    give_verdict();
  end
endmodule
`default_nettype wire
